// ==== shared/isr_pkg.sv ====
// Constants, command codes and carrier structs for the status reporting block
package isr_pkg;

  // Register widths
  localparam int SUM_W = 8;
  localparam int EVT_W = 8;
  localparam int LIA_W = 16;
  localparam int FLT_W = 8;
  localparam int DATA_W = 16;
  localparam int IDX_W = 4;

  // Serial-poll summary bit positions
  localparam int SUM_STORAGE_IDLE = 0;
  localparam int SUM_COMMAND_IDLE = 1;
  localparam int SUM_FAULT = 2;
  localparam int SUM_LOCKIN = 3;
  localparam int SUM_OUTPUT_PENDING = 4;
  localparam int SUM_EVENT = 5;
  localparam int SUM_SRQ = 6;
  localparam int SUM_SOURCES = 6;

  // Standard event bit positions
  localparam int EVT_INPUT_QUEUE_OVERFLOW = 0;
  localparam int EVT_OUTPUT_QUEUE_OVERFLOW = 2;
  localparam int EVT_RUN_FAULT = 4;
  localparam int EVT_ILLEGAL_COMMAND = 5;
  localparam int EVT_FRONT_PANEL_ACTIVITY = 6;
  localparam int EVT_POWER_ON = 7;

  // Lock-in condition bit positions
  localparam int LIA_REF_UNLOCK = 0;
  localparam int LIA_REF_OUT_OF_RANGE = 1;
  localparam int LIA_STORAGE_TRIGGERED = 3;
  localparam int LIA_SIGNAL_OVERLOAD = 4;
  localparam int LIA_IF_AMP_OVERLOAD = 5;
  localparam int LIA_FILTER_OVERLOAD = 6;
  localparam int LIA_REF_CHANGE = 7;
  localparam int LIA_CHANNEL_ONE_OVERLOAD = 8;
  localparam int LIA_CHANNEL_TWO_OVERLOAD = 9;
  localparam int LIA_AUX_OVERLOAD = 10;
  localparam int LIA_RATIO_UNDERFLOW = 11;

  // Fault bit positions
  localparam int FLT_BATTERY_FAIL = 1;
  localparam int FLT_RAM_TEST_FAIL = 2;
  localparam int FLT_LOGIC_SELFTEST_FAIL = 3;
  localparam int FLT_ROM_TEST_FAIL = 4;
  localparam int FLT_FAST_TRANSFER_ABORT = 5;
  localparam int FLT_DSP_TEST_FAIL = 6;
  localparam int FLT_MATH_FAULT = 7;

  // Implemented status bits; all other flag and summary bits read zero
  localparam logic [SUM_W-1:0] SUM_VALID = 8'h7F;
  localparam logic [EVT_W-1:0] EVT_VALID = 8'hF5;
  localparam logic [LIA_W-1:0] LIA_VALID = 16'h0FFB;
  localparam logic [FLT_W-1:0] FLT_VALID = 8'hFE;

  // Reset values
  localparam logic [DATA_W-1:0] FLAGS_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] ENABLE_RESET = 16'h0000;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_SUMMARY_READ = 4'h1,
    OP_EVENT_REGISTER_READ = 4'h2,
    OP_LOCKIN_REGISTER_READ = 4'h3,
    OP_FAULT_REGISTER_READ = 4'h4,
    OP_SUMMARY_ENABLE_WRITE = 4'h5,
    OP_EVENT_ENABLE_WRITE = 4'h6,
    OP_LOCKIN_ENABLE_WRITE = 4'h7,
    OP_FAULT_ENABLE_WRITE = 4'h8,
    OP_SUMMARY_ENABLE_READ = 4'h9,
    OP_EVENT_ENABLE_READ = 4'hA,
    OP_LOCKIN_ENABLE_READ = 4'hB,
    OP_FAULT_ENABLE_READ = 4'hC,
    OP_CLEAR_ALL_STATUS = 4'hD
  } isr_op_e;

  typedef enum logic {
    CMD_IDLE = 1'b0,
    CMD_ANSWER = 1'b1
  } isr_cmd_state_e;

  typedef struct packed {
    isr_op_e op;
    logic whole;
    logic [IDX_W-1:0] bit_index;
    logic [DATA_W-1:0] value;
  } isr_cmd_s;

  typedef struct packed {
    logic input_queue_overflow;
    logic output_queue_overflow;
    logic run_fault;
    logic illegal_command;
    logic front_panel_activity;
  } isr_std_event_s;

  typedef struct packed {
    logic ref_unlock;
    logic ref_out_of_range;
    logic storage_triggered;
    logic signal_overload;
    logic if_amp_overload;
    logic filter_overload;
    logic ref_change;
    logic channel_one_overload;
    logic channel_two_overload;
    logic aux_overload;
    logic ratio_underflow;
  } isr_lockin_event_s;

  typedef struct packed {
    logic battery_fail;
    logic ram_test_fail;
    logic logic_selftest_fail;
    logic rom_test_fail;
    logic fast_transfer_abort;
    logic dsp_test_fail;
    logic math_fault;
  } isr_fault_event_s;

endpackage

// ==== logic/isr_sticky_reg.sv ====
// Sticky event register with per-bit clear; a set in the clear cycle wins
`timescale 1ns/10ps
`default_nettype none

module isr_sticky_reg
  import isr_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] VALID = '1,
  parameter logic [W-1:0] RESET_VALUE = '0
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Set and clear requests
  input wire logic [W-1:0] set_bits,
  input wire logic [W-1:0] clear_bits,
  // Stored flags
  output logic [W-1:0] flags
);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      flags <= RESET_VALUE;
    end
    else
    begin
      // Unused positions never set
      flags <= ((flags & ~clear_bits) | set_bits) & VALID;
    end
  end

endmodule // isr_sticky_reg

`default_nettype wire

// ==== logic/isr_status_top.sv ====
// Status reporting: four status registers, enables, roll-up and service request
`timescale 1ns/10ps
`default_nettype none

module isr_status_top
  import isr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Live instrument conditions
  input wire logic storage_running,
  input wire logic command_busy,
  input wire logic output_pending,
  // Event pulses
  input wire isr_std_event_s std_event,
  input wire isr_lockin_event_s lockin_event,
  input wire isr_fault_event_s fault_event,
  // Queue flush on overflow
  output logic queue_flush,
  // Command port
  input wire logic cmd_valid,
  input wire isr_cmd_s cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  // Serial poll
  input wire logic poll_strobe,
  output logic poll_valid,
  output logic [SUM_W-1:0] poll_byte,
  output logic service_request
);

  function automatic logic [DATA_W-1:0] isr_onehot(input logic [IDX_W-1:0] idx);
    isr_onehot = 16'h0001 << idx;
  endfunction

  // Clear mask for a read: whole register or only the addressed bit
  function automatic logic [DATA_W-1:0] isr_read_clear(input logic whole,
                                                       input logic [IDX_W-1:0] idx);
    isr_read_clear = whole ? 16'hFFFF : isr_onehot(idx);
  endfunction

  isr_cmd_state_e cmd_state;
  logic take;
  logic pon_armed;
  logic [EVT_W-1:0] evt_flags;
  logic [LIA_W-1:0] lia_flags;
  logic [FLT_W-1:0] flt_flags;
  logic [EVT_W-1:0] evt_set;
  logic [LIA_W-1:0] lia_set;
  logic [FLT_W-1:0] flt_set;
  logic [DATA_W-1:0] evt_clear;
  logic [DATA_W-1:0] lia_clear;
  logic [DATA_W-1:0] flt_clear;
  logic [SUM_W-1:0] sum_enable;
  logic [EVT_W-1:0] evt_enable;
  logic [LIA_W-1:0] lia_enable;
  logic [FLT_W-1:0] flt_enable;
  logic [SUM_W-1:0] summary_live;
  logic [SUM_SOURCES-1:0] sum_enabled;
  logic [SUM_SOURCES-1:0] sum_enabled_prev;
  logic [SUM_SOURCES-1:0] sum_rise;
  logic [SUM_W-1:0] stb_value;
  logic srq_pending;
  logic [DATA_W-1:0] next_rsp_data;

  assign take = cmd_valid && cmd_ready;
  assign cmd_ready = (cmd_state == CMD_IDLE);

  // Command handshake: one answer cycle after each accepted command
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cmd_state <= CMD_IDLE;
    end
    else
    begin
      case (cmd_state)
        CMD_IDLE:
        begin
          if (cmd_valid)
          begin
            cmd_state <= CMD_ANSWER;
          end
        end
        CMD_ANSWER:
        begin
          cmd_state <= CMD_IDLE;
        end
        default:
        begin
          cmd_state <= CMD_IDLE;
        end
      endcase
    end
  end

  // Power-on flag is raised by the first edge after reset release
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pon_armed <= 1'b1;
    end
    else
    begin
      pon_armed <= 1'b0;
    end
  end

  always_comb
  begin
    evt_set = '0;
    evt_set[EVT_INPUT_QUEUE_OVERFLOW] = std_event.input_queue_overflow;
    evt_set[EVT_OUTPUT_QUEUE_OVERFLOW] = std_event.output_queue_overflow;
    evt_set[EVT_RUN_FAULT] = std_event.run_fault;
    evt_set[EVT_ILLEGAL_COMMAND] = std_event.illegal_command;
    evt_set[EVT_FRONT_PANEL_ACTIVITY] = std_event.front_panel_activity;
    evt_set[EVT_POWER_ON] = pon_armed;
  end

  always_comb
  begin
    lia_set = '0;
    lia_set[LIA_REF_UNLOCK] = lockin_event.ref_unlock;
    lia_set[LIA_REF_OUT_OF_RANGE] = lockin_event.ref_out_of_range;
    lia_set[LIA_STORAGE_TRIGGERED] = lockin_event.storage_triggered;
    lia_set[LIA_SIGNAL_OVERLOAD] = lockin_event.signal_overload;
    lia_set[LIA_IF_AMP_OVERLOAD] = lockin_event.if_amp_overload;
    lia_set[LIA_FILTER_OVERLOAD] = lockin_event.filter_overload;
    lia_set[LIA_REF_CHANGE] = lockin_event.ref_change;
    lia_set[LIA_CHANNEL_ONE_OVERLOAD] = lockin_event.channel_one_overload;
    lia_set[LIA_CHANNEL_TWO_OVERLOAD] = lockin_event.channel_two_overload;
    lia_set[LIA_AUX_OVERLOAD] = lockin_event.aux_overload;
    lia_set[LIA_RATIO_UNDERFLOW] = lockin_event.ratio_underflow;
  end

  always_comb
  begin
    flt_set = '0;
    flt_set[FLT_BATTERY_FAIL] = fault_event.battery_fail;
    flt_set[FLT_RAM_TEST_FAIL] = fault_event.ram_test_fail;
    flt_set[FLT_LOGIC_SELFTEST_FAIL] = fault_event.logic_selftest_fail;
    flt_set[FLT_ROM_TEST_FAIL] = fault_event.rom_test_fail;
    flt_set[FLT_FAST_TRANSFER_ABORT] = fault_event.fast_transfer_abort;
    flt_set[FLT_DSP_TEST_FAIL] = fault_event.dsp_test_fail;
    flt_set[FLT_MATH_FAULT] = fault_event.math_fault;
  end

  // Event, lockin and fault register reads clear what they return; clear-all leaves the enables alone
  always_comb
  begin
    evt_clear = '0;
    lia_clear = '0;
    flt_clear = '0;
    if (take)
    begin
      case (cmd.op)
        OP_EVENT_REGISTER_READ: evt_clear = isr_read_clear(cmd.whole, cmd.bit_index);
        OP_LOCKIN_REGISTER_READ: lia_clear = isr_read_clear(cmd.whole, cmd.bit_index);
        OP_FAULT_REGISTER_READ: flt_clear = isr_read_clear(cmd.whole, cmd.bit_index);
        OP_CLEAR_ALL_STATUS:
        begin
          evt_clear = 16'hFFFF;
          lia_clear = 16'hFFFF;
          flt_clear = 16'hFFFF;
        end
        default:
        begin
          evt_clear = '0;
        end
      endcase
    end
  end

  // Three sticky registers plus the live summary make the four
  isr_sticky_reg #(.W(EVT_W), .VALID(EVT_VALID), .RESET_VALUE(FLAGS_RESET[EVT_W-1:0]))
    u_evt_flags
  (
    .core_clk(core_clk),
    .reset(reset),
    .set_bits(evt_set),
    .clear_bits(evt_clear[EVT_W-1:0]),
    .flags(evt_flags)
  );

  isr_sticky_reg #(.W(LIA_W), .VALID(LIA_VALID), .RESET_VALUE(FLAGS_RESET[LIA_W-1:0]))
    u_lia_flags
  (
    .core_clk(core_clk),
    .reset(reset),
    .set_bits(lia_set),
    .clear_bits(lia_clear[LIA_W-1:0]),
    .flags(lia_flags)
  );

  isr_sticky_reg #(.W(FLT_W), .VALID(FLT_VALID), .RESET_VALUE(FLAGS_RESET[FLT_W-1:0]))
    u_flt_flags
  (
    .core_clk(core_clk),
    .reset(reset),
    .set_bits(flt_set),
    .clear_bits(flt_clear[FLT_W-1:0]),
    .flags(flt_flags)
  );

  // Enable registers: whole-value write or single-bit write
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sum_enable <= ENABLE_RESET[SUM_W-1:0];
      evt_enable <= ENABLE_RESET[EVT_W-1:0];
      lia_enable <= ENABLE_RESET[LIA_W-1:0];
      flt_enable <= ENABLE_RESET[FLT_W-1:0];
    end
    else if (take)
    begin
      case (cmd.op)
        OP_SUMMARY_ENABLE_WRITE:
        begin
          if (cmd.whole)
            sum_enable <= cmd.value[SUM_W-1:0];
          else
            sum_enable[cmd.bit_index[2:0]] <= cmd.value[0];
        end
        OP_EVENT_ENABLE_WRITE:
        begin
          if (cmd.whole)
            evt_enable <= cmd.value[EVT_W-1:0];
          else
            evt_enable[cmd.bit_index[2:0]] <= cmd.value[0];
        end
        OP_LOCKIN_ENABLE_WRITE:
        begin
          if (cmd.whole)
            lia_enable <= cmd.value;
          else
            lia_enable[cmd.bit_index] <= cmd.value[0];
        end
        OP_FAULT_ENABLE_WRITE:
        begin
          if (cmd.whole)
            flt_enable <= cmd.value[FLT_W-1:0];
          else
            flt_enable[cmd.bit_index[2:0]] <= cmd.value[0];
        end
        default:
        begin
          sum_enable <= sum_enable;
        end
      endcase
    end
  end

  // Live summary; bit 6 is filled per reader below
  always_comb
  begin
    summary_live = '0;
    summary_live[SUM_STORAGE_IDLE] = ~storage_running;
    summary_live[SUM_COMMAND_IDLE] = ~command_busy;
    summary_live[SUM_FAULT] = |(flt_flags & flt_enable);
    summary_live[SUM_LOCKIN] = |(lia_flags & lia_enable);
    summary_live[SUM_OUTPUT_PENDING] = output_pending;
    summary_live[SUM_EVENT] = |(evt_flags & evt_enable);
  end

  assign sum_enabled = summary_live[SUM_SOURCES-1:0] & sum_enable[SUM_SOURCES-1:0];

  // Edge per source, so a bit that stays set asks only once
  genvar g;
  generate
    for (g = 0; g < SUM_SOURCES; g++)
    begin : g_rise
      assign sum_rise[g] = sum_enabled[g] & ~sum_enabled_prev[g];
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sum_enabled_prev <= '0;
    end
    else
    begin
      sum_enabled_prev <= sum_enabled;
    end
  end

  // Pending request; a new rise in the poll cycle wins over the clear
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      srq_pending <= 1'b0;
    end
    else if (|sum_rise)
    begin
      srq_pending <= 1'b1;
    end
    else if (poll_strobe)
    begin
      srq_pending <= 1'b0;
    end
  end

  assign service_request = srq_pending;

  // Summary read shows bit 6 as any enabled summary bit, not the poll state
  always_comb
  begin
    stb_value = summary_live;
    stb_value[SUM_SRQ] = |sum_enabled;
    stb_value = stb_value & SUM_VALID;
  end

  // Poll answer carries the pending request captured before it clears
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      poll_valid <= 1'b0;
      poll_byte <= '0;
    end
    else
    begin
      poll_valid <= poll_strobe;
      if (poll_strobe)
      begin
        poll_byte <= (summary_live | ({7'h00, srq_pending} << SUM_SRQ)) & SUM_VALID;
      end
    end
  end

  always_comb
  begin
    case (cmd.op)
      OP_SUMMARY_READ: next_rsp_data = {8'h00, stb_value};
      OP_EVENT_REGISTER_READ: next_rsp_data = {8'h00, evt_flags};
      OP_LOCKIN_REGISTER_READ: next_rsp_data = lia_flags;
      OP_FAULT_REGISTER_READ: next_rsp_data = {8'h00, flt_flags};
      OP_SUMMARY_ENABLE_READ: next_rsp_data = {8'h00, sum_enable};
      OP_EVENT_ENABLE_READ: next_rsp_data = {8'h00, evt_enable};
      OP_LOCKIN_ENABLE_READ: next_rsp_data = lia_enable;
      OP_FAULT_ENABLE_READ: next_rsp_data = {8'h00, flt_enable};
      default: next_rsp_data = '0;
    endcase
    // Single-bit query returns only the addressed bit
    if (!cmd.whole)
    begin
      next_rsp_data = {15'h0000, next_rsp_data[cmd.bit_index]};
    end
  end

  // Answer is the value before the read's own clear takes effect
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rsp_valid <= 1'b0;
      rsp_data <= '0;
    end
    else
    begin
      rsp_valid <= take;
      if (take)
      begin
        rsp_data <= next_rsp_data;
      end
    end
  end

  // Either overflow flushes both queues
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      queue_flush <= 1'b0;
    end
    else
    begin
      queue_flush <= std_event.input_queue_overflow | std_event.output_queue_overflow;
    end
  end

endmodule // isr_status_top

`default_nettype wire

// ==== bench/isr_status_chk.sv ====
// Concurrent checks on the status reporting ports
`timescale 1ns/10ps
`default_nettype none
module isr_status_chk
  import isr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Events and flush
  input wire isr_std_event_s std_event,
  input wire logic queue_flush,
  // Command port
  input wire logic cmd_valid,
  input wire isr_cmd_s cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [DATA_W-1:0] rsp_data,
  // Serial poll
  input wire logic poll_strobe,
  input wire logic poll_valid,
  input wire logic [SUM_W-1:0] poll_byte,
  input wire logic service_request
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_flush_set: assert property (
    (std_event.input_queue_overflow || std_event.output_queue_overflow) |=> queue_flush)
    else $error("queue flush missing after an overflow");
  a_flush_quiet: assert property (
    !(std_event.input_queue_overflow || std_event.output_queue_overflow) |=> !queue_flush)
    else $error("queue flush without an overflow");
  a_take_answer: assert property (
    cmd_valid && cmd_ready |=> rsp_valid && !cmd_ready)
    else $error("command taken without an answer");
  a_answer_cause: assert property (
    rsp_valid |-> $past(cmd_valid && cmd_ready))
    else $error("answer without a command");
  a_ready_back: assert property (
    rsp_valid |=> cmd_ready && !rsp_valid)
    else $error("command port not ready after answer");
  a_poll_answer: assert property (
    poll_strobe |=> poll_valid && !poll_byte[7] && poll_byte[6] == $past(service_request))
    else $error("serial poll answer wrong");
  a_poll_cause: assert property (
    poll_valid |-> $past(poll_strobe))
    else $error("poll answer without a poll");
  a_srq_holds: assert property (
    service_request && !poll_strobe |=> service_request)
    else $error("service request dropped without a poll");
  a_rsp_narrow: assert property (
    rsp_valid && $past(cmd.op) inside {OP_SUMMARY_READ, OP_EVENT_REGISTER_READ,
    OP_FAULT_REGISTER_READ} |-> rsp_data[15:8] == 8'h00)
    else $error("upper bits set on an eight bit register");

  c_take: cover property (cmd_valid && cmd_ready);
  c_srq_poll: cover property (poll_strobe && service_request);
  c_flush: cover property (queue_flush);
endmodule // isr_status_chk
`default_nettype wire

// ==== bench/isr_host_model.sv ====
// Host computer model: answers service requests with serial polls
`timescale 1ns/10ps
`default_nettype none
module isr_host_model
  import isr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Device side
  input wire logic service_request,
  input wire logic poll_valid,
  input wire logic [SUM_W-1:0] poll_byte,
  output logic poll_strobe,
  // Bench control
  input wire logic auto_poll,
  input wire logic [3:0] answer_delay,
  input wire logic manual_poll,
  output logic [SUM_W-1:0] last_byte,
  output logic [7:0] poll_count
);
  logic busy;
  logic [3:0] wait_cnt;

  // One poll in flight; a real host never overlaps them
  always_ff @(posedge core_clk)
  begin
    poll_strobe <= 1'b0;
    if (reset)
    begin
      busy <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else if (busy)
      busy <= !poll_valid;
    else if (manual_poll || (auto_poll && service_request && wait_cnt == answer_delay))
    begin
      poll_strobe <= 1'b1;
      busy <= 1'b1;
      wait_cnt <= 4'h0;
    end
    else if (auto_poll && service_request)
      wait_cnt <= wait_cnt + 4'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      last_byte <= 8'h00;
      poll_count <= 8'h00;
    end
    else if (poll_valid)
    begin
      last_byte <= poll_byte;
      poll_count <= poll_count + 8'h01;
    end
  end
endmodule // isr_host_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the status reporting block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import isr_pkg::*;
;
  typedef struct packed {
    logic [4:0] se;
    logic [10:0] le;
    logic [6:0] fe;
    logic [7:0] ee;
    logic [15:0] el;
    logic [7:0] ef;
  } isr_row_s;
  localparam isr_row_s ROWS [12] = '{
    {5'h10, 11'h400, 7'h40, 8'h01, 16'h0001, 8'h02},
    {5'h08, 11'h200, 7'h20, 8'h04, 16'h0002, 8'h04},
    {5'h04, 11'h100, 7'h10, 8'h10, 16'h0008, 8'h08},
    {5'h02, 11'h080, 7'h08, 8'h20, 16'h0010, 8'h10},
    {5'h01, 11'h040, 7'h04, 8'h40, 16'h0020, 8'h20},
    {5'h00, 11'h020, 7'h02, 8'h00, 16'h0040, 8'h40},
    {5'h00, 11'h010, 7'h01, 8'h00, 16'h0080, 8'h80},
    {5'h00, 11'h008, 7'h00, 8'h00, 16'h0100, 8'h00},
    {5'h00, 11'h004, 7'h00, 8'h00, 16'h0200, 8'h00},
    {5'h00, 11'h002, 7'h00, 8'h00, 16'h0400, 8'h00},
    {5'h00, 11'h001, 7'h00, 8'h00, 16'h0800, 8'h00},
    {5'h1F, 11'h7FF, 7'h7F, 8'h75, 16'h0FFB, 8'hFE}};

  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic storage_running = 1'b0;
  logic command_busy = 1'b0;
  logic output_pending = 1'b1;
  isr_std_event_s std_event = '0;
  isr_lockin_event_s lockin_event = '0;
  isr_fault_event_s fault_event = '0;
  logic cmd_valid = 1'b0;
  isr_cmd_s cmd = '0;
  logic poll_strobe;
  logic queue_flush, cmd_ready, rsp_valid, poll_valid, service_request;
  logic [DATA_W-1:0] rsp_data;
  logic [SUM_W-1:0] poll_byte, last_byte;
  logic [7:0] poll_count;
  logic manual_poll = 1'b0;
  logic [15:0] d;
  isr_row_s r;
  int num_errors = 0;
  int total_checks = 0;

  always #5 core_clk = ~core_clk;

  isr_status_top u_dut (.core_clk, .reset, .storage_running, .command_busy,
    .output_pending, .std_event, .lockin_event, .fault_event, .queue_flush,
    .cmd_valid, .cmd, .cmd_ready, .rsp_valid, .rsp_data, .poll_strobe,
    .poll_valid, .poll_byte, .service_request);

  isr_host_model u_host (.core_clk, .reset, .service_request, .poll_valid,
    .poll_byte, .poll_strobe, .auto_poll(1'b1), .answer_delay(4'h3), .manual_poll,
    .last_byte, .poll_count);

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, want, seen);
    end
  endtask

  // Contract fixes the answer one cycle after the take edge
  task automatic do_cmd(input isr_op_e op, input logic whole, input logic [3:0] idx,
                        input logic [15:0] val, output logic [15:0] data);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd <= '{op, whole, idx, val};
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    #1;
    check("rsp_valid", 16'(rsp_valid), 16'h0001);
    data = rsp_data;
  endtask

  task automatic rd(input isr_op_e op, input logic [15:0] want, input string name);
    logic [15:0] v;
    do_cmd(op, 1'b1, 4'h0, 16'h0000, v);
    check(name, v, want);
  endtask

  task automatic wr(input isr_op_e op, input logic [15:0] val);
    logic [15:0] v;
    do_cmd(op, 1'b1, 4'h0, val, v);
  endtask

  task automatic pulse(input logic [4:0] se, input logic [10:0] le, input logic [6:0] fe);
    @(posedge core_clk);
    std_event <= se;
    lockin_event <= le;
    fault_event <= fe;
    @(posedge core_clk);
    std_event <= '0;
    lockin_event <= '0;
    fault_event <= '0;
    #1;
  endtask

  task automatic wait_polls(input logic [7:0] n);
    for (int k = 0; k < 50 && poll_count !== n; k++)
    begin
      @(posedge core_clk);
      #1;
    end
    check("poll_count", 16'(poll_count), 16'(n));
  endtask

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    check("srq_reset", 16'(service_request), 16'h0000);
    rd(OP_EVENT_REGISTER_READ, 16'h0080, "power_on");
    rd(OP_EVENT_REGISTER_READ, 16'h0000, "event_clr");
    foreach (ROWS[i])
    begin
      r = ROWS[i];
      pulse(r.se, r.le, r.fe);
      check("flush", 16'(queue_flush), 16'(r.se[4] | r.se[3]));
      rd(OP_EVENT_REGISTER_READ, 16'(r.ee), "event");
      rd(OP_LOCKIN_REGISTER_READ, r.el, "lockin");
      rd(OP_FAULT_REGISTER_READ, 16'(r.ef), "fault");
      rd(OP_LOCKIN_REGISTER_READ, 16'h0000, "lockin_clr");
    end
    rd(OP_SUMMARY_READ, 16'h0013, "summary_live");
    @(posedge core_clk);
    storage_running <= 1'b1;
    output_pending <= 1'b0;
    rd(OP_SUMMARY_READ, 16'h0002, "summary_busy");
    wr(OP_EVENT_ENABLE_WRITE, 16'h0004);
    wr(OP_FAULT_ENABLE_WRITE, 16'h00FE);
    wr(OP_LOCKIN_ENABLE_WRITE, 16'h0020);
    pulse(5'h0A, 11'h080, 7'h01);
    rd(OP_SUMMARY_READ, 16'h0026, "summary_mask");
    pulse(5'h00, 11'h040, 7'h00);
    rd(OP_SUMMARY_READ, 16'h002E, "summary_lockin");
    wr(OP_SUMMARY_ENABLE_WRITE, 16'h0020);
    wait_polls(8'h01);
    check("poll_byte", 16'(last_byte), 16'h006E);
    check("srq_cleared", 16'(service_request), 16'h0000);
    rd(OP_SUMMARY_READ, 16'h006E, "summary_srq");
    repeat (20) @(posedge core_clk);
    check("single_srq", 16'(poll_count), 16'h0001);
    manual_poll <= 1'b1;
    @(posedge core_clk);
    manual_poll <= 1'b0;
    wait_polls(8'h02);
    check("poll_no_srq", 16'(last_byte), 16'h002E);
    do_cmd(OP_EVENT_REGISTER_READ, 1'b0, 4'h2, 16'h0000, d);
    check("event_bit", d, 16'h0001);
    rd(OP_EVENT_REGISTER_READ, 16'h0020, "event_rest");
    rd(OP_SUMMARY_READ, 16'h000E, "summary_fall");
    pulse(5'h08, 11'h000, 7'h00);
    wait_polls(8'h03);
    wr(OP_CLEAR_ALL_STATUS, 16'h0000);
    rd(OP_LOCKIN_REGISTER_READ, 16'h0000, "lockin_cls");
    rd(OP_FAULT_REGISTER_READ, 16'h0000, "fault_cls");
    rd(OP_SUMMARY_READ, 16'h0002, "summary_cls");
    // Clear-all must leave the lockin, event and fault enable registers untouched
    do_cmd(OP_LOCKIN_ENABLE_WRITE, 1'b0, 4'hB, 16'h0001, d);
    rd(OP_LOCKIN_ENABLE_READ, 16'h0820, "lockin_en");
    rd(OP_EVENT_ENABLE_READ, 16'h0004, "event_en");
    rd(OP_FAULT_ENABLE_READ, 16'h00FE, "fault_en");
    // Mid-run reset: enables drop and the power-on flag comes back
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    check("srq_reset2", 16'(service_request), 16'h0000);
    rd(OP_EVENT_REGISTER_READ, 16'h0080, "power_on2");
    rd(OP_SUMMARY_ENABLE_READ, 16'h0000, "sum_en_reset");
    report_and_stop();
  end

  // Whole run is well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    report_and_stop();
  end
endmodule // tb_top

bind isr_status_top isr_status_chk u_chk (.core_clk, .reset, .std_event, .queue_flush,
  .cmd_valid, .cmd, .cmd_ready, .rsp_valid, .rsp_data, .poll_strobe, .poll_valid,
  .poll_byte, .service_request);
`default_nettype wire
